// ---- verilog/eicp_params.svh ----
// Constants shared by the core-side port, the controller end and the offset unit.
// Assumes inclusion by bare name from files under verilog/.
`ifndef EICP_PARAMS_SVH
`define EICP_PARAMS_SVH
`define EICP_LEVEL_W 8
`define EICP_VEC_W 6
`define EICP_SS_W 4
`define EICP_VS_W 5
`define EICP_OFS_W 17
`define EICP_ADDR_W 32
`define EICP_VEC_BASE 18'h00200
`define EICP_LEVEL_NONE 8'h00
`define EICP_VI_MAX_VEC 6'h09
`define EICP_VS_32 5'h01
`define EICP_VS_64 5'h02
`define EICP_VS_128 5'h04
`define EICP_VS_256 5'h08
`define EICP_VS_512 5'h10
// Register offsets of the controller's own AHB-Lite slave.
`define EICP_OFS_LEVEL 8'h00
`define EICP_OFS_VECTOR 8'h04
`define EICP_OFS_SHADOW 8'h08
`define EICP_OFS_STATUS 8'h0c
`define EICP_OFS_EXPORT 8'h10
// Field positions.
`define EICP_FLD_IPL_LO 2
`define EICP_FLD_IPL_HI 9
`define EICP_FLD_PEND_BIT 0
`define EICP_FLD_ACK_BIT 1
`endif

// ---- verilog/eicp_pkg.sv ----
// Types shared by both ends of the external interrupt controller port.
// Assumes eicp_params.svh is on the include path.
`include "eicp_params.svh"
package eicp_pkg;
	typedef logic [`EICP_LEVEL_W-1:0] eicp_level_t;
	typedef logic [`EICP_VEC_W-1:0] eicp_vec_t;
	typedef logic [`EICP_SS_W-1:0] eicp_ss_t;
	typedef logic [`EICP_VS_W-1:0] eicp_vs_t;
	typedef logic [`EICP_OFS_W:1] eicp_ofs_t;
	typedef struct packed {
		logic [1:0] soft_req;
		logic timer_req;
		logic perf_req;
		logic debug_channel_request;
	} eicp_export_t;
	typedef enum logic [2:0] {
		EICP_IDLE = 3'b001,
		EICP_WAIT = 3'b010,
		EICP_DONE = 3'b100
	} eicp_ctl_state_t;
endpackage

// ---- verilog/eicp_if.sv ----
// Link between the core-side port and the external interrupt controller.
// Assumes both ends share hclk and hresetn.
`timescale 1ns/1ps
`default_nettype none
interface eicp_if (
	input wire logic hclk,
	input wire logic hresetn
);
	import eicp_pkg::*;
	eicp_level_t requested_priority_level;
	eicp_vec_t vector_number_in;
	eicp_ofs_t vector_offset_in;
	eicp_ss_t ext_shadow_set;
	logic ack;
	eicp_export_t exported;
	modport core (input requested_priority_level, input vector_number_in, input vector_offset_in,
		input ext_shadow_set, output ack, output exported);
	modport ctrl (output requested_priority_level, output vector_number_in, output vector_offset_in,
		output ext_shadow_set, input ack, input exported);
endinterface // eicp_if
`default_nettype wire

// ---- verilog/eicp_vec_offset.sv ----
// Vector offset unit: turns a vector number and spacing into a handler address.
// Assumes combinational use inside the core-side port.
`timescale 1ns/1ps
`default_nettype none
`include "eicp_params.svh"
module eicp_vec_offset (
	input wire eicp_pkg::eicp_vec_t vector_num,
	input wire eicp_pkg::eicp_vs_t vector_spacing,
	input wire logic [`EICP_ADDR_W-1:0] exception_base,
	output logic [`EICP_ADDR_W-1:0] vector_addr
);
	import eicp_pkg::*;
	logic [17:0] step;
	logic [17:0] offset;
	// Spacing codes map to 32..512 byte steps; other codes give no step.
	always_comb begin
		unique case (vector_spacing)
			`EICP_VS_32: step = 18'h00020;
			`EICP_VS_64: step = 18'h00040;
			`EICP_VS_128: step = 18'h00080;
			`EICP_VS_256: step = 18'h00100;
			`EICP_VS_512: step = 18'h00200;
			default: step = 18'h00000;
		endcase
		offset = `EICP_VEC_BASE + 18'(step * {12'h000, vector_num});
	end
	// Base and offset are merged by OR, so overlapping base bits must be zero.
	assign vector_addr = exception_base | {14'h0000, offset};
endmodule // eicp_vec_offset
`default_nettype wire

// ---- verilog/eicp_core_port.sv ----
// Core-side end of the external interrupt controller port.
// Assumes the interface carries controller inputs on hclk; status fields come from core CP0 logic.
`timescale 1ns/1ps
`default_nettype none
`include "eicp_params.svh"
module eicp_core_port #(
	parameter bit FULL_OFFSET = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	eicp_if.core link,
	input wire logic ext_ctrl_mode_present,
	input wire logic vs_write,
	input wire eicp_pkg::eicp_vs_t vs_wdata,
	input wire logic vectored_enable,
	input wire logic bootstrap_vectors,
	input wire logic global_int_enable,
	input wire logic exception_level,
	input wire logic error_level,
	input wire logic [31:0] status_in,
	input wire logic [1:0] soft_req,
	input wire logic timer_req,
	input wire logic perf_req,
	input wire logic debug_channel_request,
	input wire logic [`EICP_ADDR_W-1:0] exception_base,
	input wire logic exception_start,
	input wire logic [`EICP_SS_W-1:0] shadow_set_map_sel,
	output logic ext_mode,
	output logic int_pending,
	output logic [`EICP_LEVEL_W-1:0] cause_requested_priority_level_reg,
	output logic [`EICP_SS_W-1:0] ext_shadow_set_reg,
	output logic [`EICP_SS_W-1:0] current_shadow_set_reg,
	output logic [`EICP_VS_W-1:0] vector_spacing_reg,
	output logic [`EICP_ADDR_W-1:0] vector_addr_reg
);
	import eicp_pkg::*;
	eicp_level_t current_priority_level;
	logic vi_mode;
	logic take;
	logic ack_reg;
	logic [`EICP_ADDR_W-1:0] vec_addr;
	eicp_vec_t vec_sel;

	// Vector spacing is software written and resets to compatibility mode.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_spacing_reg <= 5'h00;
		end else if (vs_write) begin
			vector_spacing_reg <= vs_wdata;
		end
	end

	// Mode decode; any nonzero spacing, with vectored_enable set and bootstrap_vectors clear, enables vectoring.
	assign ext_mode = ext_ctrl_mode_present && (vector_spacing_reg != 5'h00)
		&& vectored_enable && !bootstrap_vectors;
	assign vi_mode = !ext_ctrl_mode_present && (vector_spacing_reg != 5'h00) && vectored_enable && !bootstrap_vectors;
	assign current_priority_level = status_in[`EICP_FLD_IPL_HI:`EICP_FLD_IPL_LO];

	// Export internal requests; quiet outside external mode.
	assign link.exported = ext_mode ? {soft_req, timer_req, perf_req, debug_channel_request} : 5'h00;

	// The whole 8-bit input is a single level compared as unsigned.
	assign int_pending = ext_mode && (link.requested_priority_level > current_priority_level)
		&& global_int_enable && !exception_level && !error_level;
	// Taking the exception is the one event that captures and acknowledges.
	assign take = int_pending && exception_start && !ack_reg;
	assign link.ack = ack_reg;

	// Acknowledge is a single-cycle pulse; the controller holds inputs until it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take;
		end
	end

	// Captured level stays stable for software between exceptions.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_requested_priority_level_reg <= `EICP_LEVEL_NONE;
		end else if (take) begin
			cause_requested_priority_level_reg <= link.requested_priority_level;
		end
	end

	// Shadow set comes from the controller; the map select is only used outside external mode.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_shadow_set_reg <= 4'h0;
			current_shadow_set_reg <= 4'h0;
		end else if (take) begin
			ext_shadow_set_reg <= link.ext_shadow_set;
			current_shadow_set_reg <= link.ext_shadow_set;
		end else if (exception_start && vi_mode) begin
			current_shadow_set_reg <= shadow_set_map_sel;
		end
	end

	// The vector never comes from the level; internal mode clamps to 0..9.
	assign vec_sel = ext_mode ? link.vector_number_in
		: ((link.vector_number_in > `EICP_VI_MAX_VEC) ? `EICP_VI_MAX_VEC : link.vector_number_in);

	eicp_vec_offset u_off (
		.vector_num(vec_sel),
		.vector_spacing(vector_spacing_reg),
		.exception_base(exception_base),
		.vector_addr(vec_addr)
	);

	// Handler address is internal only; the vector itself is never stored for software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_addr_reg <= 32'h00000000;
		end else if (take) begin
			if (FULL_OFFSET) begin
				vector_addr_reg <= exception_base | {14'h0000, link.vector_offset_in, 1'b0};
			end else begin
				vector_addr_reg <= vec_addr;
			end
		end
	end
endmodule // eicp_core_port
`default_nettype wire

// ---- verilog/eicp_ctrl_end.sv ----
// Controller end: software sets the pending request over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "eicp_params.svh"
module eicp_ctrl_end (
	input wire logic hclk,
	input wire logic hresetn,
	eicp_if.ctrl link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	import eicp_pkg::*;
	eicp_level_t level_reg;
	eicp_vec_t vector_reg;
	eicp_ss_t shadow_reg;
	logic [`EICP_OFS_W-1:0] offset_reg;
	logic acked_reg;
	logic wr_ph_reg;
	logic [7:0] addr_ph_reg;
	logic [31:0] rd_next;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Only the top-priority request is presented; software prioritises.
	assign link.requested_priority_level = level_reg;
	assign link.vector_number_in = vector_reg;
	assign link.vector_offset_in = offset_reg;
	assign link.ext_shadow_set = shadow_reg;

	// Address phase capture for the following data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_reg <= 1'b0;
			addr_ph_reg <= 8'h00;
		end else if (hready) begin
			wr_ph_reg <= hsel && htrans[1] && hwrite;
			addr_ph_reg <= haddr[7:0];
		end
	end

	// Request fields hold until acknowledge, which clears the level.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_reg <= `EICP_LEVEL_NONE;
			vector_reg <= 6'h00;
			shadow_reg <= 4'h0;
			offset_reg <= 17'h00000;
		end else if (wr_ph_reg) begin
			unique case (addr_ph_reg)
				`EICP_OFS_LEVEL: level_reg <= hwdata[7:0];
				`EICP_OFS_VECTOR: {offset_reg, vector_reg} <= {hwdata[24:8], hwdata[5:0]};
				`EICP_OFS_SHADOW: shadow_reg <= hwdata[3:0];
				default: ;
			endcase
		end else if (link.ack) begin
			level_reg <= `EICP_LEVEL_NONE;
		end
	end

	// Sticky acknowledge flag; a new ack wins over a clear write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acked_reg <= 1'b0;
		end else if (link.ack) begin
			acked_reg <= 1'b1;
		end else if (wr_ph_reg && addr_ph_reg == `EICP_OFS_STATUS && hwdata[`EICP_FLD_ACK_BIT]) begin
			acked_reg <= 1'b0;
		end
	end

	// Read mux, registered at the address phase.
	always_comb begin
		rd_next = 32'h00000000;
		unique case (haddr[7:0])
			`EICP_OFS_LEVEL: rd_next = {24'h000000, level_reg};
			`EICP_OFS_VECTOR: rd_next = {7'h00, offset_reg, 2'h0, vector_reg};
			`EICP_OFS_SHADOW: rd_next = {28'h0000000, shadow_reg};
			`EICP_OFS_STATUS: rd_next = {30'h00000000, acked_reg, level_reg != `EICP_LEVEL_NONE};
			`EICP_OFS_EXPORT: rd_next = {27'h0000000, link.exported};
			default: rd_next = 32'h00000000;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rd_next;
		end
	end
endmodule // eicp_ctrl_end
`default_nettype wire

// ---- bench/eicp_link_monitor.sv ----
// Checker of the link between the core-side port and the controller end.
// Assumes it sits beside the interface on the shared clock and reset.
`timescale 1ns/1ps
`default_nettype none
module eicp_link_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire eicp_pkg::eicp_level_t requested_priority_level,
	input wire eicp_pkg::eicp_vec_t vector_number_in,
	input wire eicp_pkg::eicp_ofs_t vector_offset_in,
	input wire eicp_pkg::eicp_ss_t ext_shadow_set,
	input wire logic ack,
	input wire eicp_pkg::eicp_export_t exported
);
	import eicp_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A served request: one acknowledge cycle, then the level is withdrawn.
	sequence s_served;
		ack ##1 (!ack && requested_priority_level == 8'h00);
	endsequence
	chk_ack_pulse: assert property ($rose(ack) |-> s_served)
		else $error("ack not a single pulse followed by idle level");
	chk_no_double_ack: assert property (not (ack ##1 ack))
		else $error("ack high two cycles");
	chk_ack_needs_req: assert property (ack |-> $past(requested_priority_level) != 8'h00)
		else $error("ack without pending level");
	chk_level_held: assert property (ack |-> $stable(requested_priority_level))
		else $error("level moved before ack");
	chk_vector_held: assert property (ack |-> $stable(vector_number_in))
		else $error("vector moved before ack");
	chk_shadow_held: assert property (ack |-> $stable(ext_shadow_set))
		else $error("shadow set moved before ack");
	chk_reset_idle: assert property ($rose(hresetn) |-> requested_priority_level == 8'h00 && !ack)
		else $error("link not idle after reset");
	chk_idle_no_ack: assert property (requested_priority_level == 8'h00 |=> !ack)
		else $error("ack while nothing pending");
endmodule // eicp_link_monitor
`default_nettype wire

// ---- bench/ext_interrupt_ctrl_port_bench.sv ----
// Bench: both link ends joined, software on AHB-Lite, pipeline side driven directly.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ext_interrupt_ctrl_port_bench;
	import eicp_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, status_in = 32'h0, r;
	logic ext_ctrl_mode_present = 1'b1, vs_write = 1'b0, vectored_enable = 1'b1, bootstrap_vectors = 1'b0;
	logic global_int_enable = 1'b1, exception_level = 1'b0, error_level = 1'b0, exception_start = 1'b0;
	logic [1:0] soft_req = 2'h2;
	logic timer_req = 1'b1, perf_req = 1'b0, debug_channel_request = 1'b0, ext_mode, int_pending;
	logic [4:0] vs_wdata = 5'h00, vector_spacing_reg;
	logic [3:0] shadow_set_map_sel = 4'h0, ext_shadow_set_reg, current_shadow_set_reg;
	logic [31:0] exception_base = 32'h8000_0000, vector_addr_reg;
	logic [7:0] cause_requested_priority_level_reg;
	// Each entry: current level, then {enable, exception, error}, then expected pending, against posted level 3.
	logic [11:0] prio [5] = '{12'h3_8_0, 12'h2_8_1, 12'h2_0_0, 12'h2_c_0, 12'h2_a_0};
	int n_mismatch = 0, checks_done = 0;
	assign hready = hreadyout;
	eicp_if eicp_if_inst (.hclk, .hresetn);
	eicp_core_port #(.FULL_OFFSET(1'b0)) eicp_core_port_inst (.hclk, .hresetn, .link(eicp_if_inst.core),
		.ext_ctrl_mode_present, .vs_write, .vs_wdata, .vectored_enable, .bootstrap_vectors, .global_int_enable,
		.exception_level, .error_level, .status_in, .soft_req, .timer_req, .perf_req, .debug_channel_request,
		.exception_base, .exception_start, .shadow_set_map_sel, .ext_mode, .int_pending, .cause_requested_priority_level_reg,
		.ext_shadow_set_reg, .current_shadow_set_reg, .vector_spacing_reg, .vector_addr_reg);
	eicp_ctrl_end eicp_ctrl_end_inst (.hclk, .hresetn, .link(eicp_if_inst.ctrl), .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);
	eicp_link_monitor eicp_link_monitor_inst (.hclk, .hresetn,
		.requested_priority_level(eicp_if_inst.requested_priority_level),
		.vector_number_in(eicp_if_inst.vector_number_in), .vector_offset_in(eicp_if_inst.vector_offset_in),
		.ext_shadow_set(eicp_if_inst.ext_shadow_set), .ack(eicp_if_inst.ack), .exported(eicp_if_inst.exported));
	// A 50 MHz clock.
	always #10 hclk = ~hclk;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait for the bus ready; running out ends the run as a failure.
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	// One single-word transfer: address phase, then data phase, read data taken at its closing edge.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	// Post a request, let the pipeline start the exception and wait for the acknowledge.
	task automatic serve(input logic [7:0] lv, input logic [5:0] v, input logic [3:0] s);
		int n;
		ahb(1'b1, 32'h04, {26'h0, v}, r);
		ahb(1'b1, 32'h08, {28'h0, s}, r);
		ahb(1'b1, 32'h00, {24'h0, lv}, r);
		@(posedge hclk);
		chk("pending", 1, int_pending);
		exception_start <= 1'b1;
		n = 0;
		do begin
			@(posedge hclk);
			exception_start <= 1'b0;
			n++;
		end while (eicp_if_inst.ack !== 1'b1 && n < 20);
		chk("ack", 1, eicp_if_inst.ack);
		if (n >= 20) stop_test();
	endtask
	// Main sequence: reset, mode gating, priority compare, capture and vector offsets, registers.
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("spacing", 0, vector_spacing_reg);
		chk("mode0", 0, ext_mode);
		vs_wdata <= 5'h01;
		vs_write <= 1'b1;
		@(posedge hclk);
		vs_write <= 1'b0;
		bootstrap_vectors <= 1'b1;
		@(posedge hclk);
		chk("bev", 0, ext_mode);
		chk("exp_off", 0, eicp_if_inst.exported);
		bootstrap_vectors <= 1'b0;
		vectored_enable <= 1'b0;
		@(posedge hclk);
		chk("iv", 0, ext_mode);
		vectored_enable <= 1'b1;
		ext_ctrl_mode_present <= 1'b0;
		@(posedge hclk);
		chk("ext_ctrl_mode_present", 0, ext_mode);
		ext_ctrl_mode_present <= 1'b1;
		@(posedge hclk);
		chk("mode1", 1, ext_mode);
		chk("exp", 5'h14, eicp_if_inst.exported);
		ahb(1'b0, 32'h10, 0, r);
		chk("exp_reg", 32'h14, r);
		$display("test mode done");
		ahb(1'b1, 32'h00, 32'h3, r);
		for (int k = 0; k < 5; k++) begin
			status_in <= {22'h0, 4'h0, prio[k][11:8], 2'h0};
			{global_int_enable, exception_level, error_level} <= prio[k][7:5];
			@(posedge hclk);
			@(posedge hclk);
			chk("compare", prio[k][0], int_pending);
		end
		{global_int_enable, exception_level, error_level} <= 3'b100;
		status_in <= 32'h0;
		$display("test compare done");
		for (int i = 0; i < 5; i++) begin
			vs_wdata <= 5'h01 << i;
			vs_write <= 1'b1;
			@(posedge hclk);
			vs_write <= 1'b0;
			for (int j = 0; j < 2; j++) begin
				serve(8'h05 + i, j ? 6'h3f : 6'h01, i + j);
				chk("cause", 8'h05 + i, cause_requested_priority_level_reg);
				chk("ess", i + j, ext_shadow_set_reg);
				chk("css", i + j, current_shadow_set_reg);
				chk("vaddr", 32'h8000_0200 + (j ? 63 : 1) * (32 << i), vector_addr_reg);
			end
		end
		$display("test vectors done");
		ahb(1'b1, 32'h00, 32'h7, r);
		@(posedge hclk);
		chk("hold", 8'h09, cause_requested_priority_level_reg);
		ahb(1'b0, 32'h0c, 0, r);
		chk("status", 32'h3, r);
		chk("okay", 0, hresp);
		ahb(1'b1, 32'h00, 32'h0, r);
		ahb(1'b1, 32'h0c, 32'h2, r);
		ahb(1'b0, 32'h0c, 0, r);
		chk("clear", 32'h0, r);
		ahb(1'b1, 32'h20, 32'hffff_ffff, r);
		ahb(1'b0, 32'h20, 0, r);
		chk("unmapped", 32'h0, r);
		$display("test registers done");
		stop_test();
	end
endmodule // ext_interrupt_ctrl_port_bench
`default_nettype wire
